// ---- verilog/prb_pkg.sv ----
// Shared constants for the program ROM page banking ends
`default_nettype none
package prb_pkg;
  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int PC_W      = 12;
  localparam int LOW_W     = 11;
  localparam int PAGE_W    = 3;
  localparam int ROM_AW    = 14;
  localparam int DATA_W    = 8;
  localparam int DADDR_W   = 8;
  localparam int STACK_N   = 6;
  localparam int LEVEL_W   = 3;
  // ****************************************************************
  // Map and values
  // ****************************************************************
  localparam logic [DADDR_W-1:0] PAGE_SEL_ADDR = 8'hCA;
  localparam logic [PAGE_W-1:0]  STATIC_PAGE   = 3'h1;
  localparam logic [DATA_W-1:0]  FILL_BYTE     = 8'hFF;
  localparam logic [DATA_W-1:0]  UNUSED_MASK   = 8'h07;
  localparam int                 KB_PER_PAGE   = 2;
  localparam int                 MEM_KB_DEF    = 16;
  localparam logic [PC_W-1:0]    IRQ_VEC_LO    = 12'hFF0;
  localparam logic [PC_W-1:0]    IRQ_VEC_HI    = 12'hFF7;
  localparam logic [PC_W-1:0]    NMI_VEC       = 12'hFFC;
  localparam logic [PC_W-1:0]    RESET_VEC     = 12'hFFE;
  localparam logic [LEVEL_W-1:0] LEVEL_ZERO    = 3'h0;
  localparam logic [LEVEL_W-1:0] LEVEL_ONE     = 3'h1;
  localparam logic [LEVEL_W-1:0] LEVEL_FULL    = 3'h6;
  localparam logic [PC_W-1:0]    PC_ZERO       = 12'h000;
  localparam logic [ROM_AW-1:0]  ROM_ZERO      = 14'h0000;
  localparam logic [DATA_W-1:0]  BYTE_ZERO     = 8'h00;
endpackage : prb_pkg
`default_nettype wire

// ---- verilog/prb_if.sv ----
// Link between the core fetch side and the page banking logic
`default_nettype none
interface prb_if;
  import prb_pkg::*;
  logic                fetchReq;
  logic [PC_W-1:0]     fetchPc;
  logic                fetchAck;
  logic [DATA_W-1:0]   fetchByte;
  logic                fetchBad;
  logic                dataWr;
  logic [DADDR_W-1:0]  dataAddr;
  logic [DATA_W-1:0]   dataWdata;
  logic                stackPush;
  logic                stackPop;
  logic [PC_W-1:0]     stackIn;
  logic [PC_W-1:0]     stackTop;
  logic [LEVEL_W-1:0]  stackLevel;

  modport banker (
    input  fetchReq, fetchPc, dataWr, dataAddr, dataWdata, stackPush, stackPop, stackIn,
    output fetchAck, fetchByte, fetchBad, stackTop, stackLevel
  );
  modport core (
    output fetchReq, fetchPc, dataWr, dataAddr, dataWdata, stackPush, stackPop, stackIn,
    input  fetchAck, fetchByte, fetchBad, stackTop, stackLevel
  );
endinterface : prb_if
`default_nettype wire

// ---- verilog/prb_banker.sv ----
// Program space page banking, return stack and ROM address path
//
// Our own choice: strobed register access.
`default_nettype none
module prb_banker #(
  parameter int MEM_KBYTES = prb_pkg::MEM_KB_DEF
) (
  input  wire logic                         mclk,
  input  wire logic                         resetn,
  prb_if.banker                             bus,
  output logic [prb_pkg::ROM_AW-1:0]        romAddr,
  output logic                              romRead,
  input  wire logic [prb_pkg::DATA_W-1:0]   romData
);
  import prb_pkg::*;

  // ****************************************************************
  // Variant limits
  // ****************************************************************
  // Only 8, 12 and 16 are meaningful sizes; anything else up to 16 rounds down to whole pages
  // Fetches past the last page are answered, not dropped, so the core never stalls
  localparam logic [PAGE_W-1:0] LAST_PAGE = PAGE_W'(MEM_KBYTES / KB_PER_PAGE - 1);

  // ****************************************************************
  // Page select register
  // ****************************************************************
  logic [PAGE_W-1:0] page_number_bits;
  wire               pageSelHit;
  wire               pageSelWrite;

  assign pageSelHit   = (bus.dataAddr == PAGE_SEL_ADDR);
  assign pageSelWrite = bus.dataWr & pageSelHit;

  // no reset value
  // Left unreset on purpose: software must load it before any banked fetch
  always_ff @(posedge mclk) begin
    if (pageSelWrite) begin
      page_number_bits <= bus.dataWdata[PAGE_W-1:0];
    end
  end
  // no read path
  // The register has no read path; a core that needs the value keeps its image

  // ****************************************************************
  // Fetch address formation
  // ****************************************************************
  wire                counter_top_bit;
  wire [LOW_W-1:0]    pcLow;
  wire [PAGE_W-1:0]   fetchPage;
  wire [ROM_AW-1:0]   next_romAddr;
  wire                pageBeyondEnd;

  assign counter_top_bit = bus.fetchPc[PC_W-1];
  assign pcLow           = bus.fetchPc[LOW_W-1:0];

  assign fetchPage = counter_top_bit ? STATIC_PAGE : page_number_bits;

  assign next_romAddr = {fetchPage, pcLow};

  assign pageBeyondEnd = (fetchPage > LAST_PAGE);

  // vectors reachable
  // Vectors sit in the top of the static page, reached whatever the page value

  // ****************************************************************
  // ROM access pipeline
  // ****************************************************************
  logic romBusy;
  logic romBad;

  // page sampled at request
  // The page is taken with the request, so a write in the same cycle or
  // later only reaches the following fetch
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      romAddr <= ROM_ZERO;
    end else if (bus.fetchReq) begin
      romAddr <= next_romAddr;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      romBusy <= 1'b0;
      romBad  <= 1'b0;
    end else begin
      romBusy <= bus.fetchReq;
      romBad  <= bus.fetchReq & pageBeyondEnd;
    end
  end

  assign romRead = romBusy;

  // ****************************************************************
  // Fetch answer
  // ****************************************************************
  wire [DATA_W-1:0] next_fetchByte;

  // fill outside memory
  // Pages past the variant end answer with the reserved fill byte
  assign next_fetchByte = romBad ? FILL_BYTE : romData;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      bus.fetchByte <= BYTE_ZERO;
      bus.fetchAck  <= 1'b0;
      bus.fetchBad  <= 1'b0;
    end else begin
      bus.fetchAck <= romBusy;
      bus.fetchBad <= romBusy & romBad;
      if (romBusy) begin
        bus.fetchByte <= next_fetchByte;
      end
    end
  end

  // ****************************************************************
  // Return address stack
  // ****************************************************************
  logic [PC_W-1:0]    stackMem [STACK_N];
  logic [LEVEL_W-1:0] stackLevel;
  wire                doPush;
  wire                doPop;
  wire                stackFull;
  wire                stackEmpty;
  wire [LEVEL_W-1:0]  next_stackLevel;

  assign stackFull  = (stackLevel == LEVEL_FULL);
  assign stackEmpty = (stackLevel == LEVEL_ZERO);
  // Push and pop together cancel; a pop on empty is ignored
  assign doPush = bus.stackPush & ~bus.stackPop;
  assign doPop  = bus.stackPop & ~bus.stackPush & ~stackEmpty;

  // Overflow loses the oldest entry, as a shift stack does
  assign next_stackLevel = doPush ? (stackFull ? stackLevel : stackLevel + LEVEL_ONE)
                         : doPop  ? stackLevel - LEVEL_ONE
                         : stackLevel;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      stackLevel <= LEVEL_ZERO;
    end else begin
      stackLevel <= next_stackLevel;
    end
  end

  // six entry shift stack
  // A shift stack costs more flops than a pointer but keeps the top in a fixed register
  genvar gi;
  generate
    for (gi = 0; gi < STACK_N; gi++) begin : g_stack
      wire [PC_W-1:0] pushVal;
      wire [PC_W-1:0] popVal;
      if (gi == 0) begin : g_first
        assign pushVal = bus.stackIn;
      end else begin : g_mid
        assign pushVal = stackMem[gi-1];
      end
      if (gi == STACK_N - 1) begin : g_last
        assign popVal = PC_ZERO;
      end else begin : g_low
        assign popVal = stackMem[gi+1];
      end
      always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
          stackMem[gi] <= PC_ZERO;
        end else if (doPush) begin
          stackMem[gi] <= pushVal;
        end else if (doPop) begin
          stackMem[gi] <= popVal;
        end
      end
    end
  endgenerate

  assign bus.stackTop   = stackMem[0];
  assign bus.stackLevel = stackLevel;

endmodule : prb_banker
`default_nettype wire

// ---- verilog/prb_core_end.sv ----
// Core side of the banking link: fetch requests, page writes, stack
`default_nettype none
module prb_core_end (
  input  wire logic                         mclk,
  input  wire logic                         resetn,
  prb_if.core                               bus,
  input  wire logic                         cmdFetch,
  input  wire logic [prb_pkg::PC_W-1:0]     cmdPc,
  input  wire logic                         cmdPageWrite,
  input  wire logic [prb_pkg::PAGE_W-1:0]   cmdPage,
  input  wire logic                         cmdPush,
  input  wire logic                         cmdPop,
  input  wire logic [prb_pkg::PC_W-1:0]     cmdRetAddr,
  output logic [prb_pkg::DATA_W-1:0]        fetchedByte,
  output logic                              fetchDone,
  output logic                              fetchOutside,
  output logic [prb_pkg::PAGE_W-1:0]        pageImage,
  output logic                              pageRefused,
  output logic [prb_pkg::PC_W-1:0]          retTop,
  output logic [prb_pkg::LEVEL_W-1:0]       retLevel
);
  import prb_pkg::*;

  // ****************************************************************
  // Page change policy
  // ****************************************************************
  logic lastFetchLow;
  logic writePending;
  wire  pageAccept;

  // only from static page
  // A page change while running banked code would pull the floor away
  assign pageAccept = cmdPageWrite & ~lastFetchLow & ~writePending;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      lastFetchLow <= 1'b0;
    end else if (cmdFetch) begin
      lastFetchLow <= ~cmdPc[PC_W-1];
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pageImage    <= STATIC_PAGE;
      writePending <= 1'b0;
      pageRefused  <= 1'b0;
    end else begin
      pageRefused  <= cmdPageWrite & ~pageAccept;
      writePending <= pageAccept;
      if (pageAccept) begin
        pageImage <= cmdPage;
      end
    end
  end

  // ****************************************************************
  // Link drive
  // ****************************************************************
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      bus.dataWr    <= 1'b0;
      bus.dataAddr  <= PAGE_SEL_ADDR;
      bus.dataWdata <= BYTE_ZERO;
    end else begin
      bus.dataWr <= writePending;
      if (writePending) begin
        bus.dataWdata <= {{(DATA_W-PAGE_W){1'b0}}, pageImage} & UNUSED_MASK;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      bus.fetchReq  <= 1'b0;
      bus.fetchPc   <= RESET_VEC;
      bus.stackPush <= 1'b0;
      bus.stackPop  <= 1'b0;
      bus.stackIn   <= PC_ZERO;
    end else begin
      bus.fetchReq  <= cmdFetch;
      bus.stackPush <= cmdPush;
      bus.stackPop  <= cmdPop;
      if (cmdFetch) begin
        bus.fetchPc <= cmdPc;
      end
      if (cmdPush) begin
        bus.stackIn <= cmdRetAddr;
      end
    end
  end

  // ****************************************************************
  // Answers back to the user side
  // ****************************************************************
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      fetchedByte  <= BYTE_ZERO;
      fetchDone    <= 1'b0;
      fetchOutside <= 1'b0;
    end else begin
      fetchDone    <= bus.fetchAck;
      fetchOutside <= bus.fetchAck & bus.fetchBad;
      if (bus.fetchAck) begin
        fetchedByte <= bus.fetchByte;
      end
    end
  end

  assign retTop   = bus.stackTop;
  assign retLevel = bus.stackLevel;

endmodule : prb_core_end
`default_nettype wire

// ---- verif/prb_assertions.sv ----
// Checks on the link between the core end and the banker
`default_nettype none
module prb_assertions (
  input wire logic                        mclk,
  input wire logic                        resetn,
  input wire logic                        fetchReq,
  input wire logic [prb_pkg::PC_W-1:0]    fetchPc,
  input wire logic                        fetchAck,
  input wire logic                        fetchBad,
  input wire logic                        dataWr,
  input wire logic [prb_pkg::DADDR_W-1:0] dataAddr,
  input wire logic [prb_pkg::DATA_W-1:0]  dataWdata,
  input wire logic                        stackPush,
  input wire logic                        stackPop,
  input wire logic [prb_pkg::PC_W-1:0]    stackIn,
  input wire logic [prb_pkg::PC_W-1:0]    stackTop,
  input wire logic [prb_pkg::LEVEL_W-1:0] stackLevel
);
  timeunit 1ns;
  timeprecision 1ns;
  import prb_pkg::*;
  // ************
  // Properties
  // ************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  a_ack_follows_req: assert property (fetchReq |-> ##2 fetchAck)
    else $error("fetch answer late or missing");
  a_ack_has_req: assert property (fetchAck |-> $past(fetchReq, 2))
    else $error("fetch answer without request");
  a_static_in_range: assert property (fetchReq && fetchPc[PC_W-1] |-> ##2 fetchAck && !fetchBad)
    else $error("static page fetch flagged outside");
  a_bad_with_ack: assert property (fetchBad |-> fetchAck)
    else $error("outside flag without answer");
  a_write_target: assert property (dataWr |-> dataAddr == PAGE_SEL_ADDR
    && (dataWdata & ~UNUSED_MASK) == BYTE_ZERO)
    else $error("page write to wrong place or upper bits set");
  a_level_bound: assert property (stackLevel <= LEVEL_FULL)
    else $error("stack level above six");
  a_push_grows: assert property (stackPush && !stackPop && stackLevel < LEVEL_FULL
    |=> stackLevel == $past(stackLevel) + LEVEL_ONE)
    else $error("push did not raise level");
  a_push_top: assert property (stackPush && !stackPop |=> stackTop == $past(stackIn))
    else $error("push did not set top");
  a_stack_idle: assert property (!stackPush && !stackPop |=> $stable(stackLevel) && $stable(stackTop))
    else $error("stack moved without an operation");
  c_outside: cover property (fetchAck && fetchBad);
  c_page_write: cover property (dataWr);
  c_full_push: cover property (stackPush && stackLevel == LEVEL_FULL);
endmodule : prb_assertions
`default_nettype wire

// ---- verif/testbench.sv ----
// Self-checking bench joining the core end and the banker
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin miscompares++; $display("wrong value at %0t: got %0h expected %0h", $time, g, e); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import prb_pkg::*;
  logic                mclk = 1'b0;
  logic                resetn = 1'b0;
  logic                cmdFetch = 1'b0, cmdPageWrite = 1'b0, cmdPush = 1'b0, cmdPop = 1'b0;
  logic [PC_W-1:0]     cmdPc = PC_ZERO, cmdRetAddr = PC_ZERO, retTop;
  logic [PAGE_W-1:0]   cmdPage = 3'h0, pageImage;
  logic [DATA_W-1:0]   fetchedByte, romData, keep;
  logic                fetchDone, fetchOutside, pageRefused, romRead;
  logic [LEVEL_W-1:0]  retLevel;
  logic [ROM_AW-1:0]   romAddr;
  int                  miscompares = 0;
  int                  checked = 0;
  prb_if bus ();
  always #25 mclk = ~mclk;
  // ************
  // ROM and ends
  // ************
  // reserved areas hold the fill byte
  function automatic logic [DATA_W-1:0] rom_byte(input logic [ROM_AW-1:0] a);
    logic [PAGE_W-1:0] pg;
    logic [LOW_W-1:0]  o;
    logic              rsv;
    pg  = a[ROM_AW-1:LOW_W];
    o   = a[LOW_W-1:0];
    rsv = (pg == 3'h0 && o < 11'h080) || (pg > STATIC_PAGE && o < 11'h010)
       || (pg == STATIC_PAGE && o >= 11'h7A0 && o <= 11'h7EF)
       || (pg == STATIC_PAGE && o >= 11'h7F8 && o <= 11'h7FB);
    return rsv ? FILL_BYTE : (a[7:0] ^ {2'h0, a[13:8]});
  endfunction : rom_byte
  // Every page gives distinct bytes, so a wrong page shows
  // Data only while the read stands, so a mistimed sample shows too
  assign romData = romRead ? rom_byte(romAddr) : BYTE_ZERO;
  prb_core_end i_prb_core_end (.mclk(mclk), .resetn(resetn), .bus(bus),
    .cmdFetch(cmdFetch), .cmdPc(cmdPc), .cmdPageWrite(cmdPageWrite), .cmdPage(cmdPage),
    .cmdPush(cmdPush), .cmdPop(cmdPop), .cmdRetAddr(cmdRetAddr), .fetchedByte(fetchedByte),
    .fetchDone(fetchDone), .fetchOutside(fetchOutside), .pageImage(pageImage),
    .pageRefused(pageRefused), .retTop(retTop), .retLevel(retLevel));
  // Twelve kilobytes so pages 6 and 7 lie past the end
  prb_banker #(.MEM_KBYTES(12)) i_prb_banker (.mclk(mclk), .resetn(resetn), .bus(bus),
    .romAddr(romAddr), .romRead(romRead), .romData(romData));
  prb_assertions i_prb_assertions (.mclk(mclk), .resetn(resetn), .fetchReq(bus.fetchReq),
    .fetchPc(bus.fetchPc), .fetchAck(bus.fetchAck), .fetchBad(bus.fetchBad),
    .dataWr(bus.dataWr), .dataAddr(bus.dataAddr), .dataWdata(bus.dataWdata),
    .stackPush(bus.stackPush), .stackPop(bus.stackPop), .stackIn(bus.stackIn),
    .stackTop(bus.stackTop), .stackLevel(bus.stackLevel));
  task automatic complete_run();
    if (miscompares == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run
  task automatic fetch(input logic [PC_W-1:0] pc, input logic [DATA_W-1:0] b, input logic bad);
    int n;
    n = 0;
    cmdFetch <= 1'b1;
    cmdPc    <= pc;
    @(posedge mclk);
    cmdFetch <= 1'b0;
    do begin
      @(posedge mclk);
      n++;
    end while (fetchDone !== 1'b1 && n < 10);
    if (fetchDone !== 1'b1) begin
      miscompares++;
      complete_run();
    end else begin
      `CHK(fetchedByte, b)
      `CHK(fetchOutside, bad)
    end
  endtask : fetch
  task automatic page_write(input logic [PAGE_W-1:0] p, input logic refused);
    cmdPageWrite <= 1'b1;
    cmdPage      <= p;
    @(posedge mclk);
    cmdPageWrite <= 1'b0;
    @(posedge mclk);
    `CHK(pageRefused, refused)
    repeat (2) @(posedge mclk);
  endtask : page_write
  task automatic run_static();
    logic [PC_W-1:0] v[5];
    v = '{RESET_VEC, NMI_VEC, IRQ_VEC_LO, IRQ_VEC_HI, 12'h800};
    `CHK(pageImage, STATIC_PAGE)
    foreach (v[i]) fetch(v[i], rom_byte({STATIC_PAGE, v[i][10:0]}), 1'b0);
  endtask : run_static
  task automatic run_pages();
    for (int p = 0; p < 8; p++) begin
      fetch(12'hF05, rom_byte({STATIC_PAGE, 11'h705}), 1'b0);
      page_write(p[2:0], 1'b0);
      `CHK(pageImage, p[2:0])
      // pages past the end read fill
      fetch(12'h123, (p > 5) ? FILL_BYTE : rom_byte({p[2:0], 11'h123}), p > 5);
    end
  endtask : run_pages
  task automatic run_alias();
    fetch(12'hF00, rom_byte({STATIC_PAGE, 11'h700}), 1'b0);
    page_write(STATIC_PAGE, 1'b0);
    fetch(12'h7FE, rom_byte(14'h0FFE), 1'b0);
    keep = fetchedByte;
    fetch(RESET_VEC, rom_byte(14'h0FFE), 1'b0);
    `CHK(fetchedByte, keep)
  endtask : run_alias
  task automatic run_refuse();
    fetch(12'h055, rom_byte(14'h0855), 1'b0);
    page_write(3'h4, 1'b1);
    `CHK(pageImage, STATIC_PAGE)
    fetch(12'h055, rom_byte(14'h0855), 1'b0);
  endtask : run_refuse
  task automatic stack_ops(input int n, input logic pop);
    for (int i = 0; i < n; i++) begin
      cmdPush    <= !pop;
      cmdPop     <= pop;
      cmdRetAddr <= 12'h100 + i[11:0];
      @(posedge mclk);
    end
    cmdPush <= 1'b0;
    cmdPop  <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask : stack_ops
  task automatic run_stack();
    stack_ops(7, 1'b0);
    `CHK(retLevel, LEVEL_FULL)
    `CHK(retTop, 12'h106)
    stack_ops(1, 1'b1);
    `CHK(retTop, 12'h105)
    stack_ops(6, 1'b1);
    `CHK(retLevel, LEVEL_ZERO)
    `CHK(retTop, PC_ZERO)
  endtask : run_stack
  initial begin
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    run_static();
    run_pages();
    run_alias();
    run_refuse();
    run_stack();
    complete_run();
  end
endmodule : testbench
`default_nettype wire
